// ---- src/mcs_params.svh ----
// constants for the memory interface clock select block
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// output control codes
`define MCS_MODE_CLOCK      2'h0
`define MCS_MODE_LOW        2'h1
`define MCS_MODE_FLOAT      2'h2
`define MCS_MODE_FLOAT_ALT  2'h3

// divider select codes for the second clock output
`define MCS_DIV_1           2'h0
`define MCS_DIV_2           2'h1
`define MCS_DIV_4           2'h2
`define MCS_DIV_4_ALT       2'h3

// reset and start values
`define MCS_CNT_INIT        2'h0
`define MCS_LVL_INIT        1'h0
`define MCS_STRAP_RST       1'h0
`define MCS_OUT_RST         1'h0
`define MCS_OE_A_RST        1'h0
`define MCS_OE_B_RST        1'h1

// system clock period in ns, 20 MHz
`define MCS_CLK_PERIOD_NS   50

`endif

// ---- src/mcs_pkg.sv ----
// types for the memory interface clock select block
`include "mcs_params.svh"

package mcs_pkg;

  typedef enum logic [1:0] {
    MCS_OUT_CLOCK     = `MCS_MODE_CLOCK,
    MCS_OUT_LOW       = `MCS_MODE_LOW,
    MCS_OUT_FLOAT     = `MCS_MODE_FLOAT,
    MCS_OUT_FLOAT_ALT = `MCS_MODE_FLOAT_ALT
  } mcs_out_mode_t;

  typedef enum logic [1:0] {
    MCS_DIV_BY1     = `MCS_DIV_1,
    MCS_DIV_BY2     = `MCS_DIV_2,
    MCS_DIV_BY4     = `MCS_DIV_4,
    MCS_DIV_BY4_ALT = `MCS_DIV_4_ALT
  } mcs_div_t;

  typedef enum logic [1:0] {
    MCS_ST_RESET = 2'b00,
    MCS_ST_BOOT  = 2'b01,
    MCS_ST_RUN   = 2'b10
  } mcs_state_t;

endpackage : mcs_pkg

// ---- src/mcs_clk_if.sv ----
// signals between the control logic and the clock front end
`timescale 1ns/1ps

interface mcs_clk_if;
  import mcs_pkg::*;

  logic     src_sel;
  mcs_div_t div_sel;
  logic     lvl;
  logic     rise;
  logic     div_out;
  logic     quarter;

  modport front (
    input  src_sel,
    input  div_sel,
    output lvl,
    output rise,
    output div_out,
    output quarter
  );

  modport ctrl (
    output src_sel,
    output div_sel,
    input  lvl,
    input  rise,
    input  div_out,
    input  quarter
  );

endinterface : mcs_clk_if

// ---- src/mcs_clk_front.sv ----
// source selection, edge detect and divider for the memory clock
`timescale 1ns/1ps
`include "mcs_params.svh"

module mcs_clk_front
  import mcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic internal_sys_clk_c,
  input wire logic ext_mem_clk_in,
  mcs_clk_if.front cif
);

  // no reset here: the divider has to keep running while reset is held
  logic       lvl_ff  = `MCS_LVL_INIT;
  logic       prev_ff = `MCS_LVL_INIT;
  logic [1:0] cnt_ff  = `MCS_CNT_INIT;

  always_ff @(posedge clk_sys) begin
    lvl_ff  <= cif.src_sel ? ext_mem_clk_in : internal_sys_clk_c;
    prev_ff <= lvl_ff;
  end

  assign cif.rise = lvl_ff & ~prev_ff;

  // counting rising edges keeps divided edges on the selected clock's edges
  always_ff @(posedge clk_sys) begin
    if (cif.rise) begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end

  always_comb begin
    case (cif.div_sel)
      MCS_DIV_BY1: cif.div_out = lvl_ff;
      MCS_DIV_BY2: cif.div_out = cnt_ff[0];
      default:     cif.div_out = cnt_ff[1];
    endcase
  end

  assign cif.lvl     = lvl_ff;
  assign cif.quarter = cnt_ff[1];

  // split per source so the unknown history at the first edge stays vacuous
  ext_select_a: assert property (
    @(posedge clk_sys)
    $past(cif.src_sel) |-> lvl_ff == $past(ext_mem_clk_in))
    else $error("selected clock level does not follow external clock");

  int_select_a: assert property (
    @(posedge clk_sys)
    !$past(cif.src_sel) |-> lvl_ff == $past(internal_sys_clk_c))
    else $error("selected clock level does not follow internal clock");

  quarter_edge_a: assert property (
    @(posedge clk_sys)
    $changed(cnt_ff[1]) |-> $past(cif.rise) && $past(cnt_ff[0]))
    else $error("quarter clock moved away from a source edge");

  half_edge_a: assert property (
    @(posedge clk_sys)
    $past(cif.rise) |-> $changed(cnt_ff[0]))
    else $error("half rate clock missed a source edge");

endmodule : mcs_clk_front

// ---- src/mcs_top.sv ----
// memory interface clock select and output clock generation
//
// Notes on behaviour
// - select pin low internal, high external clock
// - output A drives clock, low, or floats
// - output A floats throughout reset
// - after reset strap0 sel0: A floats
// - after reset otherwise A toggles selected clock
// - output B is clock divided 1, 2, 4
// - output B can be held low or floated
// - during reset B toggles at quarter rate
// - after reset strap0 sel0: B held low
// - after reset otherwise B toggles quarter rate
// - strap latched as reset is released
// - hold with float bit 0 keeps clocking
// - hold with float bit 1 floats output, except B during reset
// - off mode floats both clock outputs
`timescale 1ns/1ps
`include "mcs_params.svh"

module mcs_top
  import mcs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       internal_sys_clk_c,
  input  wire logic       ext_mem_clk_in,
  input  wire logic       mem_clk_src_sel,
  input  wire logic       boot_strap_pin,
  input  wire logic [1:0] mem_global_ctrl_a_mode,
  input  wire logic       mem_global_ctrl_a_clk_out_float_in_hold,
  input  wire logic [1:0] mem_global_ctrl_b_mode,
  input  wire logic [1:0] mem_global_ctrl_b_div,
  input  wire logic       mem_global_ctrl_b_clk_out_float_in_hold,
  input  wire logic       ctrl_apply,
  input  wire logic       hold_active,
  input  wire logic       trst_n,
  input  wire logic       debug_pin_zero,
  input  wire logic       debug_pin_one_off_n,
  output logic            mem_clk_out_a,
  output logic            mem_clk_out_a_oe,
  output logic            mem_clk_out_b,
  output logic            mem_clk_out_b_oe,
  output logic            boot_config_active
);

  mcs_clk_if cif ();

  mcs_clk_front u_front (
    .clk_sys            (clk_sys),
    .internal_sys_clk_c (internal_sys_clk_c),
    .ext_mem_clk_in     (ext_mem_clk_in),
    .cif                (cif)
  );

  mcs_state_t    state_ff;
  mcs_state_t    nxt_state;
  logic          strap_ff;
  logic          out_a_ff;
  logic          oe_a_ff;
  logic          out_b_ff;
  logic          oe_b_ff;
  logic          nxt_out_a;
  logic          nxt_oe_a;
  logic          nxt_out_b;
  logic          nxt_oe_b;
  logic          off_mode;
  logic          boot_quiet;
  mcs_out_mode_t mode_a;
  mcs_out_mode_t mode_b;

  assign mode_a = mcs_out_mode_t'(mem_global_ctrl_a_mode);
  assign mode_b = mcs_out_mode_t'(mem_global_ctrl_b_mode);

  assign off_mode = ~trst_n & debug_pin_zero & ~debug_pin_one_off_n;

  // strap and live select pick the post-reset behaviour
  assign boot_quiet = ~strap_ff & ~mem_clk_src_sel;

  assign cif.src_sel = mem_clk_src_sel;

  // divide by four until software applies its own settings
  always_comb begin
    if (state_ff == MCS_ST_RUN) begin
      cif.div_sel = mcs_div_t'(mem_global_ctrl_b_div);
    end else begin
      cif.div_sel = MCS_DIV_BY4;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MCS_ST_RESET: nxt_state = MCS_ST_BOOT;
      MCS_ST_BOOT: begin
        if (ctrl_apply) begin
          nxt_state = MCS_ST_RUN;
        end
      end
      MCS_ST_RUN:   nxt_state = MCS_ST_RUN;
      default:      nxt_state = MCS_ST_RESET;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= MCS_ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // caught at the first edge after release, the pin is still settled from reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strap_ff <= `MCS_STRAP_RST;
    end else if (state_ff == MCS_ST_RESET) begin
      strap_ff <= boot_strap_pin;
    end
  end

  // first output: clock, low or float
  always_comb begin
    nxt_out_a = `MCS_OUT_RST;
    nxt_oe_a  = 1'h0;
    case (state_ff)
      MCS_ST_RESET: begin
        nxt_oe_a  = ~boot_quiet;
        nxt_out_a = cif.lvl;
      end
      MCS_ST_BOOT: begin
        nxt_oe_a  = ~boot_quiet;
        nxt_out_a = cif.lvl;
      end
      MCS_ST_RUN: begin
        case (mode_a)
          MCS_OUT_CLOCK: begin
            nxt_oe_a  = 1'h1;
            nxt_out_a = cif.lvl;
          end
          MCS_OUT_LOW: begin
            nxt_oe_a  = 1'h1;
            nxt_out_a = 1'h0;
          end
          default: begin
            nxt_oe_a  = 1'h0;
            nxt_out_a = 1'h0;
          end
        endcase
      end
      default: begin
        nxt_oe_a  = 1'h0;
        nxt_out_a = 1'h0;
      end
    endcase
    if (hold_active && mem_global_ctrl_a_clk_out_float_in_hold) begin
      nxt_oe_a = 1'h0;
    end
    if (off_mode) begin
      nxt_oe_a = 1'h0;
    end
  end

  // second output: divided clock, low or float
  always_comb begin
    nxt_out_b = `MCS_OUT_RST;
    nxt_oe_b  = 1'h1;
    case (state_ff)
      MCS_ST_RESET, MCS_ST_BOOT: begin
        nxt_oe_b  = 1'h1;
        nxt_out_b = boot_quiet ? 1'h0 : cif.div_out;
      end
      MCS_ST_RUN: begin
        case (mode_b)
          MCS_OUT_CLOCK: begin
            nxt_oe_b  = 1'h1;
            nxt_out_b = cif.div_out;
          end
          MCS_OUT_LOW: begin
            nxt_oe_b  = 1'h1;
            nxt_out_b = 1'h0;
          end
          default: begin
            nxt_oe_b  = 1'h0;
            nxt_out_b = 1'h0;
          end
        endcase
      end
      default: begin
        nxt_oe_b  = 1'h1;
        nxt_out_b = 1'h0;
      end
    endcase
    if (hold_active && mem_global_ctrl_b_clk_out_float_in_hold) begin
      nxt_oe_b = 1'h0;
    end
    if (off_mode) begin
      nxt_oe_b = 1'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      out_a_ff <= `MCS_OUT_RST;
      oe_a_ff  <= `MCS_OE_A_RST;
    end else begin
      out_a_ff <= nxt_out_a;
      oe_a_ff  <= nxt_oe_a;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      out_b_ff <= `MCS_OUT_RST;
      oe_b_ff  <= `MCS_OE_B_RST;
    end else begin
      out_b_ff <= nxt_out_b;
      oe_b_ff  <= nxt_oe_b;
    end
  end

  assign mem_clk_out_a    = out_a_ff;
  assign mem_clk_out_a_oe = oe_a_ff;
  // the divider keeps running in reset, so b bypasses its reset flop there
  assign mem_clk_out_b    = resetn ? out_b_ff : cif.quarter;
  assign mem_clk_out_b_oe = resetn ? oe_b_ff : ~off_mode;
  assign boot_config_active = (state_ff != MCS_ST_RUN);

  reset_float_a_a: assert property (
    @(posedge clk_sys)
    !resetn |-> !mem_clk_out_a_oe)
    else $error("first clock output driven during reset");

  reset_quarter_b_a: assert property (
    @(posedge clk_sys)
    !resetn && !off_mode |-> mem_clk_out_b_oe && (mem_clk_out_b == cif.quarter)
      && (cif.div_sel == MCS_DIV_BY4))
    else $error("second clock output not at quarter rate during reset");

  strap_latch_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_ff == MCS_ST_RESET) |=> (strap_ff == $past(boot_strap_pin))
      && (state_ff == MCS_ST_BOOT))
    else $error("strap not caught at reset release");

  strap_hold_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_ff != MCS_ST_RESET) |=> $stable(strap_ff))
    else $error("strap value changed after reset release");

  boot_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_ff == MCS_ST_BOOT) && boot_quiet |=> !mem_clk_out_a_oe)
    else $error("first clock output driven after quiet boot");

  boot_low_b_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_ff == MCS_ST_BOOT) && boot_quiet && !off_mode && !hold_active
      |=> mem_clk_out_b_oe && !mem_clk_out_b)
    else $error("second clock output not held low after quiet boot");

  boot_clock_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_ff == MCS_ST_BOOT) && !boot_quiet && !off_mode && !hold_active
      |=> mem_clk_out_a_oe && (mem_clk_out_a == $past(cif.lvl)))
    else $error("first clock output not following selected clock after boot");

  boot_quarter_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_ff == MCS_ST_BOOT) && !boot_quiet && !off_mode && !hold_active
      |=> mem_clk_out_b_oe && (mem_clk_out_b == $past(cif.quarter)))
    else $error("second clock output not at quarter rate after boot");

  run_modes_a_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_ff == MCS_ST_RUN) && (mode_a == MCS_OUT_LOW) && !off_mode && !hold_active
      |=> mem_clk_out_a_oe && !mem_clk_out_a)
    else $error("first clock output not held low");

  run_float_b_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_ff == MCS_ST_RUN) && (mode_b == MCS_OUT_FLOAT) |=> !mem_clk_out_b_oe)
    else $error("second clock output not floated");

  run_divide_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_ff == MCS_ST_RUN) && (mode_b == MCS_OUT_CLOCK) && !off_mode && !hold_active
      |=> mem_clk_out_b_oe && (mem_clk_out_b == $past(cif.div_out)))
    else $error("second clock output not the divided clock");

  hold_clocking_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    hold_active && !mem_global_ctrl_a_clk_out_float_in_hold && !off_mode
      && (state_ff == MCS_ST_RUN) && (mode_a == MCS_OUT_CLOCK)
      |=> mem_clk_out_a_oe && (mem_clk_out_a == $past(cif.lvl)))
    else $error("first clock output stopped in hold");

  hold_float_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    hold_active && mem_global_ctrl_b_clk_out_float_in_hold |=> !mem_clk_out_b_oe)
    else $error("second clock output driven in hold with float set");

  off_float_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    off_mode |=> !mem_clk_out_a_oe && !mem_clk_out_b_oe)
    else $error("clock outputs driven in off mode");

endmodule : mcs_top

// ---- tb/mcs_clk_src_model.sv ----
// free-running clock source model for the internal and external clock inputs
`timescale 1ns/1ps

module mcs_clk_src_model #(
  parameter int HALF_CYCLES = 3
) (
  input  wire logic clk_sys,
  output logic      clk_out
);
  int   cnt_ff = 0;
  // declared start level keeps one driver and a known level from time zero
  logic clk_ff = 1'b0;

  assign clk_out = clk_ff;

  // moves on the falling edge only, so the block never samples mid-change
  always @(negedge clk_sys) begin
    if (cnt_ff == HALF_CYCLES - 1) begin
      cnt_ff <= 0;
      clk_ff <= ~clk_ff;
    end else begin
      cnt_ff <= cnt_ff + 1;
    end
  end
endmodule : mcs_clk_src_model

// ---- tb/memory_interface_clock_select_tb_top.sv ----
// self-checking testbench for the memory clock select block
`timescale 1ns/1ps

module memory_interface_clock_select_tb_top;
  import mcs_pkg::*;

  logic       clk_sys = 1'b0;
  logic       resetn  = 1'b0;
  logic       int_clk;
  logic       ext_clk;
  logic       sel     = 1'b0;
  logic       strap   = 1'b0;
  logic [1:0] a_mode  = 2'h0;
  logic       a_hz    = 1'b0;
  logic [1:0] b_mode  = 2'h0;
  logic [1:0] b_div   = 2'h0;
  logic       b_hz    = 1'b0;
  logic       apply   = 1'b0;
  logic       hold    = 1'b0;
  logic       trst_n  = 1'b1;
  logic       dbg0    = 1'b0;
  logic       dbg1_n  = 1'b1;
  logic       clk_a;
  logic       a_oe;
  logic       clk_b;
  logic       b_oe;
  logic       boot_act;
  int         bad_count = 0;
  int         check_count = 0;

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  mcs_clk_src_model #(.HALF_CYCLES(2)) i_int_src (.clk_sys(clk_sys), .clk_out(int_clk));
  mcs_clk_src_model #(.HALF_CYCLES(3)) i_ext_src (.clk_sys(clk_sys), .clk_out(ext_clk));

  mcs_top i_mcs_top (
    .clk_sys(clk_sys), .resetn(resetn), .internal_sys_clk_c(int_clk),
    .ext_mem_clk_in(ext_clk), .mem_clk_src_sel(sel), .boot_strap_pin(strap),
    .mem_global_ctrl_a_mode(a_mode), .mem_global_ctrl_a_clk_out_float_in_hold(a_hz),
    .mem_global_ctrl_b_mode(b_mode), .mem_global_ctrl_b_div(b_div),
    .mem_global_ctrl_b_clk_out_float_in_hold(b_hz), .ctrl_apply(apply),
    .hold_active(hold), .trst_n(trst_n), .debug_pin_zero(dbg0),
    .debug_pin_one_off_n(dbg1_n), .mem_clk_out_a(clk_a), .mem_clk_out_a_oe(a_oe),
    .mem_clk_out_b(clk_b), .mem_clk_out_b_oe(b_oe), .boot_config_active(boot_act)
  );

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_num(input string what, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_num

  // cycles between two rising edges; -1 when the output does not rise twice within 120 cycles
  task automatic period_of(input logic pick_b, output int p);
    logic prev;
    logic cur;
    int   n;
    int   k;
    p = 0;
    n = 0;
    k = 0;
    prev = pick_b ? clk_b : clk_a;
    while (k < 2 && n < 120) begin
      @(negedge clk_sys);
      cur = pick_b ? clk_b : clk_a;
      n++;
      if (k == 1) p++;
      if (!prev && cur) k++;
      prev = cur;
    end
    if (k < 2) p = -1;
  endtask : period_of

  task automatic do_reset(input logic s, input logic src);
    int p;
    @(negedge clk_sys);
    resetn = 1'b0;
    strap  = s;
    sel    = src;
    apply  = 1'b0;
    repeat (5) @(negedge clk_sys);
    check_bit("a enable in reset", 1'b0, a_oe);
    period_of(1'b1, p);
    check_num("b period in reset", src ? 24 : 16, p);
    check_bit("a enable in reset", 1'b0, a_oe);
    resetn = 1'b1;
    @(negedge clk_sys);
    strap = ~s;
    repeat (3) @(negedge clk_sys);
  endtask : do_reset

  task automatic set_ctrl(input logic [1:0] am, input logic ah, input logic [1:0] bm,
                          input logic [1:0] bd, input logic bh);
    a_mode = am;
    a_hz   = ah;
    b_mode = bm;
    b_div  = bd;
    b_hz   = bh;
    repeat (3) @(negedge clk_sys);
  endtask : set_ctrl

  task automatic t_boot_quiet;
    int p;
    do_reset(1'b0, 1'b0);
    check_bit("a enable quiet", 1'b0, a_oe);
    check_bit("boot active", 1'b1, boot_act);
    period_of(1'b1, p);
    check_num("b rises quiet", -1, p);
    check_bit("b level quiet", 1'b0, clk_b);
    check_bit("b enable quiet", 1'b1, b_oe);
  endtask : t_boot_quiet

  task automatic t_boot_run(input logic s, input logic src);
    int p;
    do_reset(s, src);
    check_bit("a enable boot", 1'b1, a_oe);
    period_of(1'b0, p);
    check_num("a period boot", src ? 6 : 4, p);
    period_of(1'b1, p);
    check_num("b period boot", src ? 24 : 16, p);
  endtask : t_boot_run

  task automatic t_ctrl;
    int p;
    int ex[4] = '{4, 8, 16, 16};
    do_reset(1'b1, 1'b0);
    set_ctrl(2'h2, 1'b0, 2'h2, 2'h0, 1'b0);
    check_bit("a enable before apply", 1'b1, a_oe);
    apply = 1'b1;
    @(negedge clk_sys);
    apply = 1'b0;
    repeat (2) @(negedge clk_sys);
    check_bit("boot active", 1'b0, boot_act);
    for (int m = 0; m < 4; m++) begin
      set_ctrl(m[1:0], 1'b0, m[1:0], 2'h0, 1'b0);
      check_bit("a enable mode", m < 2, a_oe);
      check_bit("b enable mode", m < 2, b_oe);
      if (m == 1) begin
        check_bit("a held low", 1'b0, clk_a);
        check_bit("b held low", 1'b0, clk_b);
      end
    end
    set_ctrl(2'h0, 1'b0, 2'h0, 2'h0, 1'b0);
    period_of(1'b0, p);
    check_num("a period run", 4, p);
    for (int d = 0; d < 4; d++) begin
      set_ctrl(2'h0, 1'b0, 2'h0, d[1:0], 1'b0);
      period_of(1'b1, p);
      check_num("b divided period", ex[d], p);
    end
  endtask : t_ctrl

  task automatic t_hold;
    int p;
    hold = 1'b1;
    set_ctrl(2'h0, 1'b0, 2'h0, 2'h1, 1'b0);
    period_of(1'b0, p);
    check_num("a period hold", 4, p);
    period_of(1'b1, p);
    check_num("b period hold", 8, p);
    set_ctrl(2'h0, 1'b1, 2'h0, 2'h1, 1'b1);
    check_bit("a enable hold", 1'b0, a_oe);
    check_bit("b enable hold", 1'b0, b_oe);
    hold = 1'b0;
    set_ctrl(2'h0, 1'b1, 2'h0, 2'h1, 1'b1);
    check_bit("a enable after hold", 1'b1, a_oe);
  endtask : t_hold

  task automatic t_off;
    trst_n = 1'b0;
    dbg0   = 1'b1;
    repeat (3) @(negedge clk_sys);
    check_bit("a enable not off", 1'b1, a_oe);
    dbg1_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    check_bit("a enable off", 1'b0, a_oe);
    check_bit("b enable off", 1'b0, b_oe);
    trst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check_bit("b enable after off", 1'b1, b_oe);
  endtask : t_off

  initial begin
    #(50 * 20000);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_boot_quiet();
    t_boot_run(1'b1, 1'b0);
    t_boot_run(1'b0, 1'b1);
    t_boot_run(1'b1, 1'b1);
    t_ctrl();
    t_hold();
    t_off();
    tally_and_finish();
  end
endmodule : memory_interface_clock_select_tb_top
